// file: src/tssc_top.sv
/*
 * Timer start/stop control: interval timer, waveform timer and capture
 * timer counter behind an AHB-Lite slave, with status/mask interrupt.
 * Assumes one 200 MHz clock hclk, asynchronous active-low hresetn, a
 * single AHB-Lite master doing word transfers, and a capture pin that is
 * asynchronous to hclk.
 */
`timescale 1ns/100ps
module tssc_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins
  input  wire logic        meas_pin,
  output logic             irq
);

  // ****************************************************************
  // count source
  // ****************************************************************
  tssc_src_if src ();
  logic [7:0] src_div_q;
  assign src.div = src_div_q;

  tssc_srcgen u_srcgen (
    .hclk    (hclk),
    .hresetn (hresetn),
    .src     (src)
  );

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] addr_q;
  logic       acc_go;

  assign acc_go = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= acc_go && hwrite;
      rd_pend_q <= acc_go && !hwrite;
      if (acc_go) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  logic wr_it, wr_wt, wr_os, wr_rl, wr_msk, wr_div, wr_itc, wr_wtc;
  assign wr_it  = wr_pend_q && addr_q == tssc_pkg::ITMR_MODE_OFF;
  assign wr_itc = wr_pend_q && addr_q == tssc_pkg::ITMR_COUNT_OFF;
  assign wr_wt  = wr_pend_q && addr_q == tssc_pkg::WTMR_MODE_OFF;
  assign wr_os  = wr_pend_q && addr_q == tssc_pkg::WTMR_OS_OFF;
  assign wr_rl  = wr_pend_q && addr_q == tssc_pkg::WTMR_RELOAD_OFF;
  assign wr_wtc = wr_pend_q && addr_q == tssc_pkg::WTMR_COUNT_OFF;
  assign wr_msk = wr_pend_q && addr_q == tssc_pkg::IRQ_MASK_OFF;
  assign wr_div = wr_pend_q && addr_q == tssc_pkg::SRC_DIV_OFF;

  // ****************************************************************
  // capture pin synchroniser and edge
  // ****************************************************************
  logic meas_s1_q, meas_s2_q, meas_s3_q, meas_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_s1_q <= 1'b0;
      meas_s2_q <= 1'b0;
      meas_s3_q <= 1'b0;
    end else begin
      meas_s1_q <= meas_pin;
      meas_s2_q <= meas_s1_q;
      meas_s3_q <= meas_s2_q;
    end
  end
  assign meas_edge = meas_s2_q && !meas_s3_q;

  // ****************************************************************
  // interval timer
  // ****************************************************************
  logic [2:0]  it_mode_q;
  logic        it_run_q;
  logic        it_req_q;
  logic        it_edge_q;
  logic        it_und_q;
  logic [7:0]  it_pre_q;
  logic [7:0]  it_cnt_q;
  logic        it_pre_unf;
  logic        it_ppm;

  assign it_ppm     = it_mode_q == tssc_pkg::ITMR_MODE_PPM;
  assign it_pre_unf = it_run_q && src.tick && it_pre_q == 8'h00;

  // run request and handshake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      it_req_q <= 1'b0;
      it_run_q <= 1'b0;
    end else begin
      if (wr_it) begin
        it_req_q <= hwdata[tssc_pkg::ITMR_RUN_BIT];
      end
      if (src.tick) begin
        it_run_q <= it_req_q;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      it_mode_q <= tssc_pkg::ITMR_MODE_TIMER;
    end else if (wr_it) begin
      it_mode_q <= hwdata[tssc_pkg::ITMR_MODE_LSB +: 3];
    end
  end

  // prescaler and counter, separate bytes of one word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      it_pre_q <= tssc_pkg::CNT_RST[7:0];
      it_cnt_q <= tssc_pkg::CNT_RST[7:0];
    end else if (wr_itc) begin
      it_pre_q <= hwdata[7:0];
      it_cnt_q <= hwdata[15:8];
    end else begin
      if (it_run_q && src.tick) begin
        it_pre_q <= it_pre_q - 8'h01;
      end
      // edge restarts the period at once, not only on a tick
      if (it_ppm && it_run_q && meas_edge) begin
        it_cnt_q <= tssc_pkg::CNT_RST[7:0];
      end else if (it_pre_unf) begin
        it_cnt_q <= it_cnt_q - 8'h01;
      end
    end
  end

  // pulse period flags: hardware set wins over zero-write clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      it_edge_q <= 1'b0;
      it_und_q  <= 1'b0;
    end else begin
      if (it_ppm && it_run_q && (meas_edge || it_pre_unf)) begin
        it_edge_q <= 1'b1;
      end else if (wr_it && !hwdata[tssc_pkg::ITMR_EDGE_BIT]) begin
        it_edge_q <= 1'b0;
      end
      if (it_ppm && it_pre_unf && it_cnt_q == 8'h00) begin
        it_und_q <= 1'b1;
      end else if (wr_it && !hwdata[tssc_pkg::ITMR_UND_BIT]) begin
        it_und_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // waveform timer
  // ****************************************************************
  logic [1:0]  wt_mode_q;
  logic        wt_req_q;
  logic        wt_run_q;
  logic        wt_os_q;
  logic [15:0] wt_rl_q;
  logic [15:0] wt_cnt_q;
  logic        wt_oneshot;
  logic        wt_stop_rl;
  logic        wt_unf;

  assign wt_oneshot = wt_mode_q == tssc_pkg::WTMR_MODE_OS ||
                      wt_mode_q == tssc_pkg::WTMR_MODE_WOS;
  assign wt_stop_rl = wt_oneshot &&
                      ((wr_os && !hwdata[tssc_pkg::WTMR_OS_BIT] && wt_os_q)
                      || (src.tick && wt_run_q && !wt_req_q));
  assign wt_unf     = wt_run_q && src.tick && wt_cnt_q == 16'h0000 &&
                      (!wt_oneshot || wt_os_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wt_req_q <= 1'b0;
      wt_run_q <= 1'b0;
    end else begin
      if (wr_wt) begin
        wt_req_q <= hwdata[tssc_pkg::WTMR_RUN_BIT];
      end
      if (src.tick) begin
        wt_run_q <= wt_req_q;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wt_mode_q <= tssc_pkg::WTMR_MODE_TIMER;
      wt_rl_q   <= tssc_pkg::CNT_RST;
    end else begin
      if (wr_wt) begin
        wt_mode_q <= hwdata[tssc_pkg::WTMR_MODE_LSB +: 2];
      end
      if (wr_rl) begin
        wt_rl_q <= hwdata[15:0];
      end
    end
  end

  // one-shot trigger, cleared by software or by its own underflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wt_os_q <= 1'b0;
    end else if (wr_os) begin
      wt_os_q <= hwdata[tssc_pkg::WTMR_OS_BIT];
    end else if (wt_unf && wt_oneshot) begin
      wt_os_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wt_cnt_q <= tssc_pkg::CNT_RST;
    end else if (wt_stop_rl) begin
      wt_cnt_q <= wt_rl_q;
    end else if (wr_wtc) begin
      wt_cnt_q <= hwdata[15:0];
    end else if (wt_unf) begin
      wt_cnt_q <= wt_rl_q;
    end else if (wt_run_q && src.tick && (!wt_oneshot || wt_os_q)) begin
      wt_cnt_q <= wt_cnt_q - 16'h0001;
    end
  end

  // ****************************************************************
  // capture timer counter, free running
  // ****************************************************************
  logic [15:0] ct_cnt_q;
  logic        ct_ovf;

  assign ct_ovf = src.tick && ct_cnt_q == 16'hFFFF;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ct_cnt_q <= tssc_pkg::CTMR_RST;
    end else if (src.tick) begin
      ct_cnt_q <= ct_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  logic [tssc_pkg::IRQ_W-1:0] st_q;
  logic [tssc_pkg::IRQ_W-1:0] msk_q;
  logic [tssc_pkg::IRQ_W-1:0] ev;
  logic                       st_rd;

  assign ev[tssc_pkg::IRQ_IT_UND]  = it_pre_unf && it_cnt_q == 8'h00;
  assign ev[tssc_pkg::IRQ_IT_EDGE] = it_ppm && it_run_q && meas_edge;
  assign ev[tssc_pkg::IRQ_WT_UND]  = wt_unf;
  assign ev[tssc_pkg::IRQ_CT_OVF]  = ct_ovf;
  assign st_rd = rd_pend_q && addr_q == tssc_pkg::IRQ_STAT_OFF;

  // read clears, a new event in the same cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q  <= '0;
      msk_q <= '0;
      irq   <= 1'b0;
    end else begin
      st_q <= ev | (st_rd ? '0 : st_q);
      if (wr_msk) begin
        msk_q <= hwdata[tssc_pkg::IRQ_W-1:0];
      end
      irq <= |((ev | (st_rd ? '0 : st_q)) & msk_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_div_q <= tssc_pkg::SRC_DIV_RST;
    end else if (wr_div) begin
      src_div_q <= hwdata[7:0];
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      tssc_pkg::ITMR_MODE_OFF: begin
        rd_d[tssc_pkg::ITMR_MODE_LSB +: 3] = it_mode_q;
        rd_d[tssc_pkg::ITMR_RUN_BIT]       = it_run_q;
        rd_d[tssc_pkg::ITMR_EDGE_BIT]      = it_edge_q;
        rd_d[tssc_pkg::ITMR_UND_BIT]       = it_und_q;
      end
      tssc_pkg::ITMR_COUNT_OFF: begin
        rd_d[15:0] = {it_cnt_q, it_pre_q};
      end
      tssc_pkg::WTMR_MODE_OFF: begin
        rd_d[tssc_pkg::WTMR_MODE_LSB +: 2] = wt_mode_q;
        rd_d[tssc_pkg::WTMR_RUN_BIT]       = wt_run_q;
      end
      tssc_pkg::WTMR_OS_OFF:     rd_d[tssc_pkg::WTMR_OS_BIT] = wt_os_q;
      tssc_pkg::WTMR_RELOAD_OFF: rd_d[15:0] = wt_rl_q;
      tssc_pkg::WTMR_COUNT_OFF:  rd_d[15:0] = wt_cnt_q;
      tssc_pkg::IRQ_STAT_OFF:    rd_d[tssc_pkg::IRQ_W-1:0] = st_q;
      tssc_pkg::IRQ_MASK_OFF:    rd_d[tssc_pkg::IRQ_W-1:0] = msk_q;
      tssc_pkg::SRC_DIV_OFF:     rd_d[7:0] = src_div_q;
      tssc_pkg::CTMR_COUNT_OFF:  rd_d[15:0] = ct_cnt_q;
      default:                   rd_d = 32'h0000_0000;
    endcase
  end

  // whole word sampled in one edge, so both bytes are coherent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc_go && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

endmodule : tssc_top

// file: src/tssc_pkg.sv
/*
 * Package for the timer start/stop control block: register offsets, field
 * positions, reset values and mode encodings.
 * Assumes a 32-bit AHB-Lite register bus, one word per register.
 */
package tssc_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ITMR_MODE_OFF   = 8'h00;
  localparam logic [7:0] ITMR_COUNT_OFF  = 8'h04;
  localparam logic [7:0] WTMR_MODE_OFF   = 8'h10;
  localparam logic [7:0] WTMR_OS_OFF     = 8'h14;
  localparam logic [7:0] WTMR_RELOAD_OFF = 8'h18;
  localparam logic [7:0] WTMR_COUNT_OFF  = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFF    = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFF    = 8'h24;
  localparam logic [7:0] SRC_DIV_OFF     = 8'h28;
  localparam logic [7:0] CTMR_COUNT_OFF  = 8'h90;

  // ****************************************************************
  // interval timer mode register fields
  // ****************************************************************
  localparam int ITMR_MODE_LSB = 0;
  localparam int ITMR_RUN_BIT  = 3;
  localparam int ITMR_EDGE_BIT = 4;
  localparam int ITMR_UND_BIT  = 5;

  // waveform timer mode and one-shot register fields
  localparam int WTMR_MODE_LSB = 0;
  localparam int WTMR_RUN_BIT  = 2;
  localparam int WTMR_OS_BIT   = 0;

  // interrupt status bits
  localparam int IRQ_IT_UND   = 0;
  localparam int IRQ_IT_EDGE  = 1;
  localparam int IRQ_WT_UND   = 2;
  localparam int IRQ_CT_OVF   = 3;
  localparam int IRQ_W        = 4;

  // ****************************************************************
  // reset values and widths
  // ****************************************************************
  localparam int          CNT_W         = 16;
  localparam logic [15:0] CNT_RST       = 16'hFFFF;
  localparam logic [7:0]  SRC_DIV_RST   = 8'h03;
  localparam logic [15:0] CTMR_RST      = 16'h0000;

  // ****************************************************************
  // mode encodings
  // ****************************************************************
  localparam logic [2:0] ITMR_MODE_TIMER = 3'h0;
  localparam logic [2:0] ITMR_MODE_PPM   = 3'h3;
  localparam logic [1:0] WTMR_MODE_TIMER = 2'h0;
  localparam logic [1:0] WTMR_MODE_OS    = 2'h2;
  localparam logic [1:0] WTMR_MODE_WOS   = 2'h3;

endpackage : tssc_pkg

// file: src/tssc_src_if.sv
/*
 * Interface carrying the count-source tick between the divider and the
 * timer core.
 * Assumes one clock, hclk.
 */
`timescale 1ns/100ps
interface tssc_src_if;
  logic [7:0] div;
  logic       tick;
  modport gen (input div, output tick);
  modport use_ (output div, input tick);
endinterface : tssc_src_if

// file: src/tssc_srcgen.sv
/*
 * Count-source generator: one-cycle tick every div+1 clocks.
 * Assumes hclk and hresetn of the timer block.
 */
`timescale 1ns/100ps
module tssc_srcgen (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // source tick
  tssc_src_if.gen   src
);
  logic [7:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q    <= 8'h00;
      src.tick <= 1'b0;
    end else if (cnt_q >= src.div) begin
      cnt_q    <= 8'h00;
      src.tick <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 8'h01;
      src.tick <= 1'b0;
    end
  end
endmodule : tssc_srcgen

// file: verification/tssc_checker.sv
/* Checker for tssc_top: bus answer, readback and interrupt properties.
   Assumes it is bound to tssc_top and sees only its ports. */
`timescale 1ns/100ps
module tssc_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins
  input wire logic        meas_pin,
  input wire logic        irq
);
  // ********
  // tracking
  // ********
  logic        rd_take;
  logic        wr_take;
  logic        rd_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        itw_q;
  logic        wtw_q;
  logic [3:0]  mask_q;

  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      rd_q   <= rd_take;
      wr_q   <= wr_take;
      addr_q <= haddr[7:0];
    end
  end

  // mode writes since reset, mask mirror
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      itw_q  <= 1'b0;
      wtw_q  <= 1'b0;
      mask_q <= 4'h0;
    end else begin
      if (wr_take && haddr[7:0] == tssc_pkg::ITMR_MODE_OFF)
        itw_q <= 1'b1;
      if (wr_take && haddr[7:0] == tssc_pkg::WTMR_MODE_OFF)
        wtw_q <= 1'b1;
      if (wr_q && addr_q == tssc_pkg::IRQ_MASK_OFF)
        mask_q <= hwdata[3:0];
    end
  end

  // ********
  // properties
  // ********
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_ZERO_WAIT: assert property (hreadyout)
    else $error("wait state inserted");
  AST_OKAY: assert property (!hresp)
    else $error("error response");
  AST_RD_HOLD: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (rd_q && addr_q == 8'h40 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CT_WIDE: assert property (
    rd_q && addr_q == tssc_pkg::CTMR_COUNT_OFF |-> hrdata[31:16] == 16'h0)
    else $error("capture count upper half not zero");
  AST_IT_IDLE: assert property (
    rd_q && addr_q == tssc_pkg::ITMR_MODE_OFF && !itw_q |-> !hrdata[3])
    else $error("interval timer running after reset");
  AST_WT_IDLE: assert property (
    rd_q && addr_q == tssc_pkg::WTMR_MODE_OFF && !wtw_q |-> !hrdata[2])
    else $error("waveform timer running after reset");
  AST_IRQ_MASK: assert property (
    mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
    else $error("interrupt with all sources masked");
endmodule : tssc_checker

bind tssc_top tssc_checker i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .meas_pin(meas_pin), .irq(irq)
);

// file: verification/tb_timer_start_stop_control.sv
/* Testbench for tssc_top: AHB-Lite register tasks and directed tests.
   Assumes the package, the design and the checker are compiled first. */
`timescale 1ns/100ps
module tb_timer_start_stop_control;
  localparam logic [7:0] NOWHERE = 8'h40;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        meas_pin;
  logic [6:0]  meas_cnt;
  logic        meas_en;
  logic        irq;
  logic [31:0] rd;
  logic [1:0]  md;
  int          failures;
  int          n_compared;

  tssc_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .meas_pin(meas_pin), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // slow square wave on the measurement pin, paused while meas_en is low
  always @(posedge hclk) begin
    if (!hresetn) begin
      meas_cnt <= 7'h00;
      meas_pin <= 1'b0;
    end else begin
      meas_cnt <= meas_cnt + 7'h01;
      if (meas_cnt == 7'h7F && meas_en)
        meas_pin <= ~meas_pin;
    end
  end

  // ********
  // tasks
  // ********
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic hang;
    failures++;
    stop_test();
  endtask : hang

  task automatic cmp(input logic [31:0] got, exp, msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
    end
  endtask : cmp

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50)
        hang();
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, msk);
    bus(1'b0, a, 32'h0, rd);
    cmp(rd, exp, msk);
  endtask : rdc

  // align to a fresh count-source tick via the capture counter
  task automatic sync_tick;
    logic [31:0] v0;
    int          n;
    bus(1'b0, tssc_pkg::CTMR_COUNT_OFF, 32'h0, v0);
    rd = v0;
    n = 0;
    while (rd === v0) begin
      n++;
      if (n > 400)
        hang();
      bus(1'b0, tssc_pkg::CTMR_COUNT_OFF, 32'h0, rd);
    end
  endtask : sync_tick

  // run bit write: old value right away, new value after the tick
  task automatic run_ctl(input logic [7:0] a, input logic [31:0] base,
                         input int rb, input logic v);
    int n;
    sync_tick();
    wr(a, base | (32'(v) << rb));
    rdc(a, 32'(!v) << rb, 32'h1 << rb);
    n = 0;
    while (rd[rb] !== v) begin
      n++;
      if (n > 300)
        hang();
      bus(1'b0, a, 32'h0, rd);
    end
    cmp(rd, 32'(v) << rb, 32'h1 << rb);
  endtask : run_ctl

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v) begin
      n++;
      if (n > 5000)
        hang();
      @(posedge hclk);
    end
    cmp({31'h0, irq}, {31'h0, v}, 32'h1);
  endtask : wait_irq

  // ********
  // tests
  // ********
  initial begin
    hresetn  = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hwdata   = 32'h0;
    meas_en  = 1'b1;
    failures = 0;
    n_compared = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(tssc_pkg::ITMR_MODE_OFF, 32'h0, 32'h8);
    rdc(tssc_pkg::WTMR_MODE_OFF, 32'h0, 32'h4);
    rdc(tssc_pkg::ITMR_COUNT_OFF, 32'(tssc_pkg::CNT_RST), 32'hFFFF);
    repeat (40) @(posedge hclk);
    rdc(tssc_pkg::ITMR_COUNT_OFF, 32'(tssc_pkg::CNT_RST), 32'hFFFF);
    rdc(tssc_pkg::SRC_DIV_OFF, 32'(tssc_pkg::SRC_DIV_RST), 32'hFF);
    $display("test reset done");
    wr(NOWHERE, 32'hFFFF_FFFF);
    rdc(NOWHERE, 32'h0, 32'hFFFF_FFFF);
    rdc(tssc_pkg::CTMR_COUNT_OFF, 32'h0, 32'hFFFF_0000);
    wr(tssc_pkg::SRC_DIV_OFF, 32'hFF);
    rdc(tssc_pkg::SRC_DIV_OFF, 32'hFF, 32'hFF);
    wr(tssc_pkg::ITMR_COUNT_OFF, 32'h1234);
    rdc(tssc_pkg::ITMR_COUNT_OFF, 32'h1234, 32'hFFFF);
    $display("test bus done");
    run_ctl(tssc_pkg::ITMR_MODE_OFF, 32'h0, 3, 1'b1);
    wr(tssc_pkg::ITMR_MODE_OFF, 32'h8);
    rdc(tssc_pkg::ITMR_MODE_OFF, 32'h8, 32'h8);
    run_ctl(tssc_pkg::ITMR_MODE_OFF, 32'h0, 3, 1'b0);
    wr(tssc_pkg::ITMR_MODE_OFF, 32'h0);
    rdc(tssc_pkg::ITMR_MODE_OFF, 32'h0, 32'h8);
    run_ctl(tssc_pkg::WTMR_MODE_OFF, 32'h0, 2, 1'b1);
    run_ctl(tssc_pkg::WTMR_MODE_OFF, 32'h0, 2, 1'b0);
    $display("test run handshake done");
    for (int i = 0; i < 2; i++) begin
      md = (i == 0) ? tssc_pkg::WTMR_MODE_OS : tssc_pkg::WTMR_MODE_WOS;
      wr(tssc_pkg::WTMR_RELOAD_OFF, 32'h50);
      wr(tssc_pkg::WTMR_MODE_OFF, {30'h0, md});
      run_ctl(tssc_pkg::WTMR_MODE_OFF, {30'h0, md}, 2, 1'b1);
      wr(tssc_pkg::WTMR_OS_OFF, 32'h1);
      rdc(tssc_pkg::WTMR_OS_OFF, 32'h1, 32'h1);
      repeat (600) @(posedge hclk);
      wr(tssc_pkg::WTMR_OS_OFF, 32'h0);
      rdc(tssc_pkg::WTMR_COUNT_OFF, 32'h50, 32'hFFFF);
      rdc(tssc_pkg::WTMR_OS_OFF, 32'h0, 32'h1);
      wr(tssc_pkg::WTMR_OS_OFF, 32'h1);
      repeat (600) @(posedge hclk);
      run_ctl(tssc_pkg::WTMR_MODE_OFF, {30'h0, md}, 2, 1'b0);
      rdc(tssc_pkg::WTMR_COUNT_OFF, 32'h50, 32'hFFFF);
    end
    $display("test one-shot reload done");
    wr(tssc_pkg::SRC_DIV_OFF, 32'h3);
    meas_en <= 1'b0;
    wr(tssc_pkg::ITMR_COUNT_OFF, 32'h0201);
    wr(tssc_pkg::ITMR_MODE_OFF, 32'h3);
    rdc(tssc_pkg::ITMR_MODE_OFF, 32'h3, 32'h37);
    wr(tssc_pkg::IRQ_MASK_OFF, 32'h1);
    rdc(tssc_pkg::IRQ_MASK_OFF, 32'h1, 32'hF);
    run_ctl(tssc_pkg::ITMR_MODE_OFF, 32'h33, 3, 1'b1);
    wait_irq(1'b1);
    wr(tssc_pkg::IRQ_MASK_OFF, 32'h0);
    wait_irq(1'b0);
    wr(tssc_pkg::IRQ_MASK_OFF, 32'h1);
    wait_irq(1'b1);
    rdc(tssc_pkg::ITMR_MODE_OFF, 32'h20, 32'h20);
    wr(tssc_pkg::ITMR_MODE_OFF, 32'h2B);
    rdc(tssc_pkg::ITMR_MODE_OFF, 32'h20, 32'h20);
    meas_en <= 1'b1;
    repeat (600) @(posedge hclk);
    run_ctl(tssc_pkg::ITMR_MODE_OFF, 32'h33, 3, 1'b0);
    rdc(tssc_pkg::IRQ_STAT_OFF, 32'h3, 32'h3);
    rdc(tssc_pkg::IRQ_STAT_OFF, 32'h0, 32'h3);
    wait_irq(1'b0);
    wr(tssc_pkg::ITMR_MODE_OFF, 32'h3);
    rdc(tssc_pkg::ITMR_MODE_OFF, 32'h0, 32'h30);
    $display("test pulse period and interrupt done");
    stop_test();
  end
endmodule : tb_timer_start_stop_control
